// ---- pkg/lbs_pkg.sv ----
// Purpose: Shared constants and types for the LED brightness shaper
// Assumes: 200 MHz core clock, three LED channels
// Notes:   Duty levels are carried in whole percent, 0 to 100
package lbs_pkg;

  localparam int unsigned LED_N = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_P1_DUTY = 8'h90;
  localparam logic [7:0] OFS_P2_DUTY = 8'h91;
  localparam logic [7:0] OFS_BR_DUTY = 8'h92;
  localparam logic [7:0] OFS_DR_DUTY = 8'h93;
  localparam logic [7:0] OFS_RAMP    = 8'h94;
  localparam logic [7:0] OFS_HOLD    = 8'h95;
  localparam logic [7:0] OFS_STAT    = 8'h96;

  localparam logic [2:0] IDX_P1   = 3'(OFS_P1_DUTY - OFS_P1_DUTY);
  localparam logic [2:0] IDX_P2   = 3'(OFS_P2_DUTY - OFS_P1_DUTY);
  localparam logic [2:0] IDX_BR   = 3'(OFS_BR_DUTY - OFS_P1_DUTY);
  localparam logic [2:0] IDX_DR   = 3'(OFS_DR_DUTY - OFS_P1_DUTY);
  localparam logic [2:0] IDX_RAMP = 3'(OFS_RAMP - OFS_P1_DUTY);
  localparam logic [2:0] IDX_HOLD = 3'(OFS_HOLD - OFS_P1_DUTY);

  localparam logic [7:0] DUTY_RST  = 8'hF0;
  localparam logic [7:0] ZERO_RST  = 8'h00;
  localparam logic [7:0] RAMP_MASK = 8'h3F;
  localparam logic [7:0] HOLD_MASK = 8'h7F;
  localparam logic [5:0][7:0] REGS_RST = {ZERO_RST, ZERO_RST, DUTY_RST,
                                          DUTY_RST, DUTY_RST, DUTY_RST};

  // Field positions
  localparam int unsigned TOP_LSB   = 4;
  localparam int unsigned FLOOR_LSB = 0;
  localparam int unsigned RISE_LSB  = 3;
  localparam int unsigned FALL_LSB  = 0;
  localparam int unsigned GAP_LSB   = 4;
  localparam int unsigned HOLDC_LSB = 0;

  // Behaviour codes on the mode inputs
  localparam logic [1:0] MODE_DIRECT  = 2'h0;
  localparam logic [1:0] MODE_PULSE1  = 2'h1;
  localparam logic [1:0] MODE_PULSE2  = 2'h2;
  localparam logic [1:0] MODE_BREATHE = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_NS         = 5;
  localparam int unsigned PWM_PERIOD_NS  = 500000;
  localparam int unsigned PWM_STEPS      = 100;
  localparam int unsigned SLOT_CYC       = PWM_PERIOD_NS / PWM_STEPS / CLK_NS;
  localparam int unsigned TICK_NS        = 100000;
  localparam int unsigned TICK_CYC       = TICK_NS / CLK_NS;
  localparam int unsigned TICKS_PER_MS   = 1000000 / TICK_NS;
  localparam int unsigned RAMP_STEP_MS   = 250;
  localparam int unsigned TOP_TIME_MS    = 2000;
  localparam int unsigned LONG_BASE_MS   = 2500;
  localparam int unsigned LONG_STEP_MS   = 500;
  localparam int unsigned MAX_HOLD_MS    = 5000;
  localparam int unsigned PERIOD_UNIT_MS = 32;

  localparam logic [15:0] RAMP_STEP_T = 16'(RAMP_STEP_MS * TICKS_PER_MS);
  localparam logic [15:0] TOP_TIME_T  = 16'(TOP_TIME_MS * TICKS_PER_MS);
  localparam logic [15:0] LONG_BASE_T = 16'(LONG_BASE_MS * TICKS_PER_MS);
  localparam logic [15:0] LONG_STEP_T = 16'(LONG_STEP_MS * TICKS_PER_MS);
  localparam logic [15:0] MAX_HOLD_T  = 16'(MAX_HOLD_MS * TICKS_PER_MS);
  localparam logic [14:0] HALF_UNIT_T = 15'(PERIOD_UNIT_MS * TICKS_PER_MS / 2);

  localparam logic [2:0] STEP_TOP_CODE  = 3'h7;
  localparam logic [3:0] HOLD_LONG_CODE = 4'h8;
  localparam logic [3:0] HOLD_LAST_CODE = 4'hC;
  localparam logic [6:0] PERIOD_MIN     = 7'h02;

  // Percent for each top code, code 15 first
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0][6:0] TOP_PCT = {
    PCT_FULL, 7'h4D, 7'h3F, 7'h35, 7'h2E, 7'h28, 7'h23, 7'h1E,
    7'h1A,    7'h17, 7'h14, 7'h11, 7'h0E, 7'h0B, 7'h09, 7'h07};

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {PH_IDLE, PH_RISE, PH_HOLD, PH_FALL, PH_GAP} lbs_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lbs_bus_t;

  typedef struct packed {
    logic [6:0] pulse_one_period;
    logic [6:0] pulse_two_period;
    logic [6:0] breathe_period;
    logic [2:0] pulse_one_count;
    logic [2:0] pulse_two_count;
  } lbs_pattern_t;

  typedef struct packed {
    logic       tick;
    logic [6:0] pct;
  } lbs_time_t;

  typedef struct packed {
    logic [19:0] slot_cnt;
    logic [19:0] tick_cnt;
    logic [6:0]  pct;
    logic        tick;
  } lbs_tb_state_t;

  typedef struct packed {
    logic [5:0][7:0]        regs;
    lbs_phase_t [LED_N-1:0] phase;
    logic [LED_N-1:0][6:0]  level;
    logic [LED_N-1:0][14:0] acc;
    logic [LED_N-1:0][15:0] wait_cnt;
    logic [LED_N-1:0][6:0]  snap_top;
    logic [LED_N-1:0][6:0]  snap_floor;
    logic [LED_N-1:0][2:0]  left;
    logic [LED_N-1:0]       act_prev;
    logic [LED_N-1:0]       pwm;
    logic [7:0]             rdata;
  } lbs_state_t;

endpackage : lbs_pkg

// ---- rtl/lbs_timebase.sv ----
// Purpose: PWM slot counter and 0.1 ms tick for the shaper
// Assumes: Counts fit in 20 bits
// Notes:   Carrier period is fixed, never touched by duty or period settings
`timescale 1ns/1ps
module lbs_timebase #(
  parameter int unsigned SLOT_CYC = lbs_pkg::SLOT_CYC,
  parameter int unsigned TICK_CYC = lbs_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              arst_n_in,
  // Time base
  output lbs_pkg::lbs_time_t     time_out
);

  lbs_pkg::lbs_tb_state_t s_reg;
  lbs_pkg::lbs_tb_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.slot_cnt == 20'(SLOT_CYC - 1)) begin
      s_next.slot_cnt = 20'h00000;
      if (s_reg.pct == 7'(lbs_pkg::PWM_STEPS - 1)) begin
        s_next.pct = 7'h00;
      end else begin
        s_next.pct = 7'(s_reg.pct + 7'h01);
      end
    end else begin
      s_next.slot_cnt = 20'(s_reg.slot_cnt + 20'h00001);
    end
    if (s_reg.tick_cnt == 20'(TICK_CYC - 1)) begin
      s_next.tick_cnt = 20'h00000;
      s_next.tick     = 1'b1;
    end else begin
      s_next.tick_cnt = 20'(s_reg.tick_cnt + 20'h00001);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign time_out = '{tick: s_reg.tick, pct: s_reg.pct};

  a_pct_wrap: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    $changed(s_reg.pct) |-> (s_reg.pct == 7'h00) || (s_reg.pct == 7'($past(s_reg.pct) + 7'h01)))
    else $error("PWM slot counter skipped a step");

endmodule : lbs_timebase

// ---- rtl/lbs_shaper.sv ----
// Purpose: Duty limits, ramps and hold delays for three LED PWM outputs
// Assumes: Behaviour mode, drive and polarity come from the LED control logic
// Notes:   Register port answers reads one cycle later, never stalls
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Contract
// - Top nibble selects maximum duty percent
// - Low nibble selects minimum duty percent
// - Four duty pairs, each resetting to F0
// - Ramp minimum up to maximum, back down
// - Direct mode duty writes act at once
// - Other modes take duty on re-activation; idle level follows the live floor
// - Rise field bits 5:3 sets ramp-up time
// - Fall field bits 2:0 sets ramp-down time
// - Hold at maximum; inverted polarity flips output
// - Breathe gap after each pulse, bits 6:4
// - Direct turn-off delay precedes ramp-down
// - Four-bit turn-off delay decode up to 5s
// - One turn-off delay shared by direct LEDs
// - Direct waveform combines all settings
// - Period in 32ms units, codes 0,1 equal
// - PWM carrier fixed near two kilohertz
module lbs_shaper #(
  parameter int unsigned SLOT_CYC = lbs_pkg::SLOT_CYC,
  parameter int unsigned TICK_CYC = lbs_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   arst_n_in,
  // Register port
  input  wire lbs_pkg::lbs_bus_t      bus_in,
  output logic [7:0]                  rd_data_out,
  // Per-LED behaviour controls and shared pattern settings
  input  wire logic [2:0][1:0]        led_mode_in,
  input  wire logic [2:0]             led_drive_in,
  input  wire logic [2:0]             led_polarity_select_in,
  input  wire lbs_pkg::lbs_pattern_t  pattern_in,
  // LED outputs
  output logic [2:0]                  led_pwm_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [6:0] top_pct(input logic [3:0] code);
    return lbs_pkg::TOP_PCT[code];
  endfunction : top_pct

  // Floor table is the top table shifted by one code
  function automatic logic [6:0] floor_pct(input logic [3:0] code);
    if (code == 4'h0) begin
      return 7'h00;
    end
    return lbs_pkg::TOP_PCT[4'(code - 4'h1)];
  endfunction : floor_pct

  function automatic logic [15:0] step_ticks(input logic [2:0] code);
    if (code == lbs_pkg::STEP_TOP_CODE) begin
      return lbs_pkg::TOP_TIME_T;
    end
    return 16'(16'(code) * lbs_pkg::RAMP_STEP_T);
  endfunction : step_ticks

  function automatic logic [15:0] hold_ticks(input logic [3:0] code);
    if (code < lbs_pkg::HOLD_LONG_CODE) begin
      return step_ticks(code[2:0]);
    end else if (code <= lbs_pkg::HOLD_LAST_CODE) begin
      return 16'(lbs_pkg::LONG_BASE_T +
                 16'(16'(code - lbs_pkg::HOLD_LONG_CODE) * lbs_pkg::LONG_STEP_T));
    end
    return lbs_pkg::MAX_HOLD_T;
  endfunction : hold_ticks

  // Half the period, one ramp direction of a pulse or breath
  function automatic logic [14:0] half_period(input logic [6:0] code);
    logic [14:0] c;
    c = 15'((code < lbs_pkg::PERIOD_MIN) ? 7'h01 : code);
    return 15'(c * lbs_pkg::HALF_UNIT_T);
  endfunction : half_period

  function automatic logic [2:0] duty_idx(input logic [1:0] md);
    unique case (md)
      lbs_pkg::MODE_DIRECT: return lbs_pkg::IDX_DR;
      lbs_pkg::MODE_PULSE1: return lbs_pkg::IDX_P1;
      lbs_pkg::MODE_PULSE2: return lbs_pkg::IDX_P2;
      default:              return lbs_pkg::IDX_BR;
    endcase
  endfunction : duty_idx

  function automatic logic reg_hit(input logic [7:0] addr);
    return (addr >= lbs_pkg::OFS_P1_DUTY) && (addr <= lbs_pkg::OFS_HOLD);
  endfunction : reg_hit

  function automatic logic [2:0] reg_idx(input logic [7:0] addr);
    return 3'(addr - lbs_pkg::OFS_P1_DUTY);
  endfunction : reg_idx

  // Fractional stepping: carry bit on top, new remainder below
  function automatic logic [15:0] ramp_acc(input logic [14:0] acc,
                                           input logic [6:0]  span,
                                           input logic [14:0] n);
    logic [15:0] sum;
    sum = 16'(acc) + 16'(span);
    if (sum >= 16'(n)) begin
      return {1'b1, 15'(sum - 16'(n))};
    end
    return {1'b0, sum[14:0]};
  endfunction : ramp_acc

  //////////////////////////////////////////////////////////////////////////////
  // Time base

  lbs_pkg::lbs_time_t tm;

  lbs_timebase #(
    .SLOT_CYC (SLOT_CYC),
    .TICK_CYC (TICK_CYC)
  ) u_timebase (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .time_out    (tm)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State

  lbs_pkg::lbs_state_t s_reg;
  lbs_pkg::lbs_state_t s_next;

  logic [7:0] ramp_reg;
  logic [7:0] hold_reg;
  logic [3:0] direct_hold_code;
  logic [2:0] breathe_gap_code;

  assign ramp_reg         = s_reg.regs[lbs_pkg::IDX_RAMP];
  assign hold_reg         = s_reg.regs[lbs_pkg::IDX_HOLD];
  assign direct_hold_code = hold_reg[lbs_pkg::HOLDC_LSB +: 4];
  assign breathe_gap_code = hold_reg[lbs_pkg::GAP_LSB +: 3];

  always_comb begin
    logic [7:0]  duty;
    logic [6:0]  top;
    logic [6:0]  flr;
    logic [6:0]  span;
    logic [6:0]  lv;
    logic [14:0] n_up;
    logic [14:0] n_dn;
    logic [14:0] a;
    logic [15:0] step;
    logic [15:0] wt;
    logic [6:0]  per;
    logic [1:0]  md;
    logic [2:0]  busy;
    logic        act;
    logic        rose;
    logic        dir;
    duty   = 8'h00;
    top    = 7'h00;
    flr    = 7'h00;
    span   = 7'h00;
    lv     = 7'h00;
    n_up   = 15'h0000;
    n_dn   = 15'h0000;
    a      = 15'h0000;
    step   = 16'h0000;
    wt     = 16'h0000;
    per    = 7'h00;
    md     = 2'h0;
    busy   = 3'h0;
    act    = 1'b0;
    rose   = 1'b0;
    dir    = 1'b0;
    s_next = s_reg;

    // Register writes, reserved bits dropped
    if (bus_in.wr && reg_hit(bus_in.addr)) begin
      unique case (reg_idx(bus_in.addr))
        lbs_pkg::IDX_RAMP: s_next.regs[reg_idx(bus_in.addr)] = bus_in.wdata & lbs_pkg::RAMP_MASK;
        lbs_pkg::IDX_HOLD: s_next.regs[reg_idx(bus_in.addr)] = bus_in.wdata & lbs_pkg::HOLD_MASK;
        default:           s_next.regs[reg_idx(bus_in.addr)] = bus_in.wdata;
      endcase
    end

    for (int i = 0; i < lbs_pkg::LED_N; i++) begin
      md   = led_mode_in[i];
      dir  = (md == lbs_pkg::MODE_DIRECT);
      act  = led_drive_in[i];
      rose = act && !s_reg.act_prev[i];
      duty = s_reg.regs[duty_idx(md)];
      // Direct follows the live register, others the activation snapshot
      top  = dir ? top_pct(duty[lbs_pkg::TOP_LSB +: 4]) : s_reg.snap_top[i];
      flr  = dir ? floor_pct(duty[lbs_pkg::FLOOR_LSB +: 4]) : s_reg.snap_floor[i];
      span = (top > flr) ? 7'(top - flr) : 7'h00;
      unique case (md)
        lbs_pkg::MODE_PULSE1: per = pattern_in.pulse_one_period;
        lbs_pkg::MODE_PULSE2: per = pattern_in.pulse_two_period;
        default:              per = pattern_in.breathe_period;
      endcase
      n_up = dir ? 15'(step_ticks(ramp_reg[lbs_pkg::RISE_LSB +: 3])) : half_period(per);
      n_dn = dir ? 15'(step_ticks(ramp_reg[lbs_pkg::FALL_LSB +: 3])) : half_period(per);
      lv   = s_reg.level[i];
      a    = s_reg.acc[i];
      wt   = s_reg.wait_cnt[i];
      s_next.act_prev[i] = act;

      unique case (s_reg.phase[i])
        lbs_pkg::PH_IDLE: begin
          lv = floor_pct(duty[lbs_pkg::FLOOR_LSB +: 4]);
          if (dir ? act : rose) begin
            s_next.phase[i]      = lbs_pkg::PH_RISE;
            a                    = 15'h0000;
            s_next.snap_top[i]   = top_pct(duty[lbs_pkg::TOP_LSB +: 4]);
            s_next.snap_floor[i] = lv;
            if (md == lbs_pkg::MODE_PULSE1) begin
              s_next.left[i] = pattern_in.pulse_one_count;
            end else if (md == lbs_pkg::MODE_PULSE2) begin
              s_next.left[i] = pattern_in.pulse_two_count;
            end else begin
              s_next.left[i] = 3'h0;
            end
          end
        end
        lbs_pkg::PH_RISE: begin
          if (dir && !act) begin
            s_next.phase[i] = lbs_pkg::PH_HOLD;
            wt              = 16'h0000;
          end else if (lv >= top) begin
            lv = top;
            if (!dir) begin
              s_next.phase[i] = lbs_pkg::PH_FALL;
              a               = 15'h0000;
            end
          end else if (n_up == 15'h0000) begin
            lv = top;
          end else if (tm.tick) begin
            step = ramp_acc(a, span, n_up);
            a    = step[14:0];
            if (step[15]) begin
              lv = 7'(lv + 7'h01);
            end
          end
        end
        lbs_pkg::PH_HOLD: begin
          // Stays at the level reached, capped at the top, until the shared delay runs out
          if (lv > top) begin
            lv = top;
          end
          if (act) begin
            s_next.phase[i] = lbs_pkg::PH_RISE;
          end else if (wt >= hold_ticks(direct_hold_code)) begin
            s_next.phase[i] = lbs_pkg::PH_FALL;
            a               = 15'h0000;
          end else if (tm.tick) begin
            wt = 16'(wt + 16'h0001);
          end
        end
        lbs_pkg::PH_FALL: begin
          if (dir && act) begin
            s_next.phase[i] = lbs_pkg::PH_RISE;
            a               = 15'h0000;
          end else if (lv <= flr) begin
            lv = flr;
            if (!dir && (s_reg.left[i] != 3'h0)) begin
              s_next.left[i]  = 3'(s_reg.left[i] - 3'h1);
              s_next.phase[i] = lbs_pkg::PH_RISE;
              a               = 15'h0000;
            end else if ((md == lbs_pkg::MODE_BREATHE) && act) begin
              s_next.phase[i] = lbs_pkg::PH_GAP;
              wt              = 16'h0000;
            end else begin
              s_next.phase[i] = lbs_pkg::PH_IDLE;
            end
          end else if (n_dn == 15'h0000) begin
            lv = flr;
          end else if (tm.tick) begin
            step = ramp_acc(a, span, n_dn);
            a    = step[14:0];
            if (step[15]) begin
              lv = 7'(lv - 7'h01);
            end
          end
        end
        lbs_pkg::PH_GAP: begin
          lv = flr;
          if (!act) begin
            s_next.phase[i] = lbs_pkg::PH_IDLE;
          end else if (wt >= step_ticks(breathe_gap_code)) begin
            s_next.phase[i] = lbs_pkg::PH_RISE;
            a               = 15'h0000;
          end else if (tm.tick) begin
            wt = 16'(wt + 16'h0001);
          end
        end
        default: begin
          s_next.phase[i] = lbs_pkg::PH_IDLE;
        end
      endcase

      // Breathing stops as soon as the drive is withdrawn
      if ((md == lbs_pkg::MODE_BREATHE) && !act) begin
        s_next.phase[i] = lbs_pkg::PH_IDLE;
      end

      s_next.level[i]    = lv;
      s_next.acc[i]      = a;
      s_next.wait_cnt[i] = wt;
      // Inverted polarity drives the complement of the duty waveform
      s_next.pwm[i] = (tm.pct < lv) ^ !led_polarity_select_in[i];
      busy[i]       = (s_reg.phase[i] != lbs_pkg::PH_IDLE);
    end

    // Read data live for exactly one cycle
    s_next.rdata = 8'h00;
    if (bus_in.rd) begin
      if (reg_hit(bus_in.addr)) begin
        s_next.rdata = s_reg.regs[reg_idx(bus_in.addr)];
      end else if (bus_in.addr == lbs_pkg::OFS_STAT) begin
        s_next.rdata = {5'h00, busy};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg      <= '0;
      s_reg.regs <= lbs_pkg::REGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_out = s_reg.rdata;
  assign led_pwm_out = s_reg.pwm;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic p1_written_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      p1_written_reg <= 1'b0;
    end else if (bus_in.wr && (bus_in.addr == lbs_pkg::OFS_P1_DUTY)) begin
      p1_written_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_duty_reset_val: assert property (
    (!p1_written_reg && bus_in.rd && (bus_in.addr == lbs_pkg::OFS_P1_DUTY))
      |=> (rd_data_out == lbs_pkg::DUTY_RST))
    else $error("Duty register lost its reset value");

  a_top_hold_cap: assert property (
    ((led_mode_in[0] == lbs_pkg::MODE_DIRECT) && (s_reg.phase[0] == lbs_pkg::PH_HOLD)
      && $past(s_reg.phase[0] == lbs_pkg::PH_HOLD)
      && $past(led_mode_in[0] == lbs_pkg::MODE_DIRECT)
      && $stable(s_reg.regs[lbs_pkg::IDX_DR]))
      |-> (s_reg.level[0] <= top_pct(s_reg.regs[lbs_pkg::IDX_DR][7:4])))
    else $error("Held level above the top duty");

  a_direct_floor_live: assert property (
    ((led_mode_in[0] == lbs_pkg::MODE_DIRECT) && $past(led_mode_in[0] == lbs_pkg::MODE_DIRECT)
      && (s_reg.phase[0] == lbs_pkg::PH_IDLE) && $past(s_reg.phase[0] == lbs_pkg::PH_IDLE)
      && $stable(s_reg.regs[lbs_pkg::IDX_DR]))
      |-> (s_reg.level[0] == floor_pct(s_reg.regs[lbs_pkg::IDX_DR][3:0])))
    else $error("Idle direct level does not follow the floor setting");

  a_rise_monotone: assert property (
    ((led_mode_in[0] != lbs_pkg::MODE_DIRECT) && (s_reg.phase[0] == lbs_pkg::PH_RISE)
      && $past(s_reg.phase[0] == lbs_pkg::PH_RISE))
      |-> (s_reg.level[0] >= $past(s_reg.level[0])))
    else $error("Level fell during a rising ramp");

  a_snapshot_stable: assert property (
    ((led_mode_in[0] != lbs_pkg::MODE_DIRECT) && (s_reg.phase[0] != lbs_pkg::PH_IDLE)
      && $past(s_reg.phase[0] != lbs_pkg::PH_IDLE))
      |-> ($stable(s_reg.snap_top[0]) && $stable(s_reg.snap_floor[0])))
    else $error("Duty snapshot changed during a running behaviour");

  a_zero_ramp_jump: assert property (
    ((led_mode_in[0] == lbs_pkg::MODE_DIRECT) && led_drive_in[0]
      && (s_reg.phase[0] == lbs_pkg::PH_RISE) && (ramp_reg[5:3] == 3'h0))
      |=> (s_reg.level[0] == $past(top_pct(s_reg.regs[lbs_pkg::IDX_DR][7:4]))))
    else $error("Zero rise time did not jump to the top level");

  a_hold_bound: assert property (
    ((s_reg.phase[0] == lbs_pkg::PH_HOLD) && $stable(hold_reg))
      |-> (s_reg.wait_cnt[0] <= hold_ticks(direct_hold_code)))
    else $error("Turn-off delay ran past its setting");

  a_gap_at_floor: assert property (
    ((s_reg.phase[0] == lbs_pkg::PH_GAP) && $past(s_reg.phase[0] == lbs_pkg::PH_GAP))
      |-> (s_reg.level[0] == s_reg.snap_floor[0]))
    else $error("Breathe gap not at the floor level");

  a_full_polarity: assert property (
    (s_reg.level[0] == lbs_pkg::PCT_FULL)
      |-> (led_pwm_out[0] == $past(led_polarity_select_in[0])))
    else $error("Full duty output ignores polarity");

endmodule : lbs_shaper

// ---- tb/lbs_led_meter.sv ----
// Purpose: LED load model, counts pin-high cycles per carrier period
// Assumes: Carrier period is PER core cycles
// Notes:   Free-running window; any alignment gives the exact high count
`timescale 1ns/1ps
module lbs_led_meter #(
  parameter int unsigned PER = 200
) (
  // Clock and pins
  input  wire logic        core_clk_in,
  input  wire logic [2:0]  pwm_in,
  // High cycles seen in the last full window
  output logic [2:0][7:0]  duty_out
);
  logic [2:0][7:0] acc_reg;
  int unsigned     cyc_reg = 0;
  always_ff @(posedge core_clk_in) begin
    cyc_reg <= (cyc_reg == PER - 1) ? 0 : cyc_reg + 1;
    for (int i = 0; i < 3; i++) begin
      acc_reg[i] <= (cyc_reg == PER - 1) ? 8'h00 : acc_reg[i] + 8'(pwm_in[i]);
      if (cyc_reg == PER - 1) duty_out[i] <= acc_reg[i] + 8'(pwm_in[i]);
    end
  end
endmodule : lbs_led_meter

// ---- tb/test_lbs_shaper.sv ----
// Purpose: Self-checking bench for the LED brightness shaper
// Assumes: Shortened carrier (200 cycles) and tick (4 cycles)
// Notes:   Duty is judged as high cycles per carrier, twice the percent
`timescale 1ns/1ps
module test_lbs_shaper;
  localparam int unsigned PER = 200;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  lbs_pkg::lbs_bus_t bus = '0;
  logic [7:0] rd;
  logic [2:0][1:0] mode = {3{lbs_pkg::MODE_DIRECT}};
  logic [2:0] drive = 3'h0;
  logic [2:0] pol = 3'h3;
  lbs_pkg::lbs_pattern_t pat = '0;
  logic [2:0] pwm;
  logic [2:0][7:0] duty;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] tab [16] = '{8'h07, 8'h09, 8'h0B, 8'h0E, 8'h11, 8'h14, 8'h17, 8'h1A,
                           8'h1E, 8'h23, 8'h28, 8'h2E, 8'h35, 8'h3F, 8'h4D, 8'h64};
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  always #2.5 core_clk = ~core_clk;
  lbs_shaper #(.SLOT_CYC(2), .TICK_CYC(4)) u_dut (.core_clk_in(core_clk),
    .arst_n_in(arst_n), .bus_in(bus), .rd_data_out(rd), .led_mode_in(mode),
    .led_drive_in(drive), .led_polarity_select_in(pol), .pattern_in(pat),
    .led_pwm_out(pwm));
  lbs_led_meter #(.PER(PER)) u_load (.core_clk_in(core_clk), .pwm_in(pwm), .duty_out(duty));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(posedge core_clk);
    `CHK("read data", e, rd)
  endtask : rd_chk
  task automatic hold_for(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold_for
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] e [8] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk(8'h90 + 8'(i), e[i]);
    $display("reset values done");
  endtask : t_reset
  task automatic t_masks();
    wr(8'h94, 8'hFF);
    rd_chk(8'h94, 8'h3F);
    wr(8'h95, 8'hFF);
    rd_chk(8'h95, 8'h7F);
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    $display("field masks done");
  endtask : t_masks
  // Drive is raised with each write and dropped for the floor check, so every code re-actuates the LEDs
  task automatic t_levels();
    for (int k = 0; k < 16; k++) begin
      drive <= 3'h5;
      wr(8'h93, {4'(k), 4'(k)});
      hold_for(3 * PER);
      `CHK("top", 8'(2 * tab[k]), duty[0])
      `CHK("inverted top", 8'(PER - 2 * tab[k]), duty[2])
      drive <= 3'h0;
      hold_for(3 * PER);
      `CHK("floor", (k == 0) ? 8'h00 : 8'(2 * tab[k - 1]), duty[0])
    end
    $display("duty levels done");
  endtask : t_levels
  // 250 ms is 2500 ticks of 4 cycles, so 10000 cycles for rise and for hold
  task automatic t_timing();
    wr(8'h93, 8'hF0);
    wr(8'h94, 8'h08);
    wr(8'h95, 8'h01);
    drive <= 3'h3;
    hold_for(5000);
    `CHK("mid rise", 1'b1, (duty[0] > 8'h3C) && (duty[0] < 8'h8C))
    hold_for(5600);
    `CHK("end rise", 8'hC8, duty[0])
    drive <= 3'h0;
    hold_for(9000);
    `CHK("hold led0", 8'hC8, duty[0])
    `CHK("hold led1", 8'hC8, duty[1])
    hold_for(2600);
    `CHK("after hold", 8'h00, duty[1])
    $display("ramp and hold timing done");
  endtask : t_timing
  // Period code 1 equals code 0: 640 cycles per ramp, so one pulse is over by 1300 cycles
  task automatic t_modes();
    wr(8'h95, 8'h10);
    pat <= '{pulse_one_period: 7'h01, pulse_two_period: 7'h01, breathe_period: 7'h01,
             pulse_one_count: 3'h1, pulse_two_count: 3'h0};
    mode <= {lbs_pkg::MODE_PULSE2, lbs_pkg::MODE_PULSE1, lbs_pkg::MODE_BREATHE};
    drive <= 3'h7;
    hold_for(2000);
    `CHK("breathe gap", 8'h00, duty[0])
    `CHK("pulse2 done", 8'hC8, duty[2])
    rd_chk(8'h96, 8'h03);
    // Live floor of 77 percent must not reach a running breath
    wr(8'h92, 8'hFF);
    hold_for(6000);
    `CHK("breathe snapshot", 8'h00, duty[0])
    `CHK("pulse1 done", 8'h00, duty[1])
    rd_chk(8'h96, 8'h01);
    drive <= 3'h0;
    hold_for(1000);
    `CHK("breathe idle", 8'h9A, duty[0])
    $display("breathe and pulse done");
  endtask : t_modes
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    hold_for(20);
    arst_n <= 1'b1;
    t_reset();
    t_masks();
    t_levels();
    t_timing();
    t_modes();
    end_sim();
  end
endmodule : test_lbs_shaper
